// File: src/mmx_pkg.sv
// package for the min-max acquisition pipeline: register map, modes, timing
// assumes a single 125 MHz aclk domain and an AXI4-Lite master
package mmx_pkg;
	localparam int CLK_MHZ = 125;
	localparam int STROBE_NS = 10;
	localparam int STROBE_CYC = (STROBE_NS * CLK_MHZ) / 1000 < 1 ? 1 : (STROBE_NS * CLK_MHZ) / 1000;
	localparam int SAMPLE_MHZ = 20;
	localparam int SAMPLE_DIV = (CLK_MHZ * 10) / (SAMPLE_MHZ * 10);
	localparam int MIN_COMPARE = 4;
	localparam logic [7:0] CODE_TOP = 8'hff;
	localparam logic [7:0] CODE_BOTTOM = 8'h00;
	localparam logic [3:0] OFS_CTRL = 4'h0;
	localparam logic [3:0] OFS_STATUS = 4'h4;
	localparam logic [3:0] OFS_PERIOD = 4'h8;
	localparam logic [3:0] OFS_WORD = 4'hc;
	localparam int CTRL_MODE_LO = 0;
	localparam int CTRL_EXCH = 2;
	localparam int CTRL_TEST_N = 3;
	localparam logic [31:0] CTRL_RESET = 32'h0000_0008;
	localparam logic [15:0] PERIOD_RESET = 16'h0004;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_DECERR = 2'h3;
	typedef enum logic [1:0] {
		MODE_SAMPLING = 2'h0,
		MODE_XY = 2'h1,
		MODE_MINMAX = 2'h2
	} mmx_mode_t;
	typedef enum logic [2:0] {
		ST_IDLE = 3'b001,
		ST_INIT = 3'b010,
		ST_TRACK = 3'b100
	} mmx_state_t;
	typedef struct packed {
		logic [15:0] word;
		logic write_grant;
		logic straight_sel;
		logic exchanged_sel;
		logic output_stage_clock;
	} mmx_mem_t;
	typedef struct packed {
		mmx_state_t st;
		logic [3:0] div;
		logic [3:0] sdiv;
		logic [3:0] phase;
		logic [2:0] strobe_cnt;
		logic sample_strobe;
		logic latch_strobe_clock;
		logic odd_phase_clock;
		logic [15:0] pcnt;
		logic [7:0] in_latch;
		logic [7:0] low_reg;
		logic [7:0] high_reg;
		logic last_max;
		logic swap_ff;
		logic [15:0] ncmp;
		mmx_mem_t mem;
		logic [31:0] ctrl;
		logic [15:0] period;
		logic awok;
		logic wok;
		logic [3:0] awaddr;
		logic [31:0] wdata;
		logic bvalid;
		logic [1:0] bresp;
		logic rvalid;
		logic [1:0] rresp;
		logic [31:0] rdata;
		logic [7:0] diag;
	} mmx_state_all_t;
endpackage

// File: src/mmx_pipeline.sv
// min-max acquisition pipeline: input latch, low/high registers, swap stage
// assumes converter bytes synchronous to aclk and an AXI4-Lite master
`timescale 1ns/100ps
module mmx_pipeline (
	// clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// converter side
	input wire logic [7:0] latch_strobe_clock_byte,
	output logic sample_strobe,
	output logic sample_clock_n,
	// acquisition memory side
	output logic [15:0] mem_word,
	output logic capture_write_grant,
	output logic straight_sel,
	output logic exchanged_sel,
	output logic output_stage_clock,
	// axi4-lite slave
	input wire logic [3:0] s_awaddr,
	input wire logic s_awvalid,
	output logic s_awready,
	input wire logic [31:0] s_wdata,
	input wire logic [3:0] s_wstrb,
	input wire logic s_wvalid,
	output logic s_wready,
	output logic [1:0] s_bresp,
	output logic s_bvalid,
	input wire logic s_bready,
	input wire logic [3:0] s_araddr,
	input wire logic s_arvalid,
	output logic s_arready,
	output logic [31:0] s_rdata,
	output logic [1:0] s_rresp,
	output logic s_rvalid,
	input wire logic s_rready
);
	mmx_pkg::mmx_state_all_t r, next_r;
	logic tick, rise_ls, fall_ls, period_end, pre_end, below_minimum_flag, above_maximum_flag;
	logic [7:0] gbus;
	logic [1:0] mode;
	logic low_register_clock, high_register_clock, even_phase_clock, store_period_clock;

	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] be);
		logic [31:0] m;
		m = old;
		for (int i = 0; i < 4; i++) begin
			if (be[i]) begin
				m[i*8 +: 8] = nw[i*8 +: 8];
			end
		end
		return m;
	endfunction

	function automatic logic known(input logic [3:0] a);
		return a == mmx_pkg::OFS_CTRL || a == mmx_pkg::OFS_STATUS || a == mmx_pkg::OFS_PERIOD || a == mmx_pkg::OFS_WORD;
	endfunction

	always_comb begin
		mode = r.ctrl[mmx_pkg::CTRL_MODE_LO +: 2];
		// a tick every half sample period; the strobe half-phases come off it
		// latch strobe toggles twice per sample period so it runs at the sample rate
		tick = r.div == 4'(mmx_pkg::SAMPLE_DIV / 2 - 1);
		rise_ls = tick && !r.latch_strobe_clock;
		fall_ls = tick && r.latch_strobe_clock;
		// test bit low hands the bus to the diagnostic counter
		gbus = r.ctrl[mmx_pkg::CTRL_TEST_N] ? r.in_latch : r.diag;
		below_minimum_flag = gbus < r.low_reg;
		above_maximum_flag = gbus > r.high_reg;
		store_period_clock = r.pcnt == 16'h0000;
		even_phase_clock = !r.odd_phase_clock;
		period_end = rise_ls && r.pcnt == r.period - 16'h0001;
		pre_end = fall_ls && r.pcnt == r.period - 16'h0001;
		low_register_clock = 1'b0;
		high_register_clock = 1'b0;
		// register loads happen on the falling strobe so the compare has settled
		if (fall_ls) begin
			case (mode)
				mmx_pkg::MODE_XY: begin
					low_register_clock = even_phase_clock;
					high_register_clock = r.odd_phase_clock;
				end
				mmx_pkg::MODE_MINMAX: begin
					low_register_clock = r.st == mmx_pkg::ST_INIT || (r.st == mmx_pkg::ST_TRACK && below_minimum_flag);
					high_register_clock = r.st == mmx_pkg::ST_INIT || (r.st == mmx_pkg::ST_TRACK && above_maximum_flag);
				end
				default: begin
					low_register_clock = r.odd_phase_clock;
					high_register_clock = !r.odd_phase_clock;
				end
			endcase
		end
	end

	always_comb begin
		next_r = r;
		next_r.div = tick ? 4'h0 : r.div + 4'h1;
		// sample clock: one low-going edge per period, strobe fires from it
		next_r.sdiv = (r.sdiv == 4'(mmx_pkg::SAMPLE_DIV - 1)) ? 4'h0 : r.sdiv + 4'h1;
		if (r.sdiv == 4'h0) begin
			next_r.strobe_cnt = 3'(mmx_pkg::STROBE_CYC);
		end else if (r.strobe_cnt != 3'h0) begin
			next_r.strobe_cnt = r.strobe_cnt - 3'h1;
		end
		next_r.sample_strobe = next_r.strobe_cnt != 3'h0;
		next_r.mem.output_stage_clock = 1'b0;
		if (tick) begin
			next_r.latch_strobe_clock = !r.latch_strobe_clock;
		end
		if (rise_ls) begin
			next_r.in_latch = latch_strobe_clock_byte;
			next_r.diag = r.diag + 8'h01;
			next_r.odd_phase_clock = !r.odd_phase_clock;
			next_r.pcnt = period_end ? 16'h0000 : r.pcnt + 16'h0001;
			next_r.ncmp = period_end ? 16'h0000 : r.ncmp + 16'h0001;
			next_r.mem.write_grant = 1'b0;
			next_r.mem.straight_sel = 1'b0;
			next_r.mem.exchanged_sel = 1'b0;
			if (r.pcnt == r.period - 16'h0002 || r.period < 16'h0002) begin
				next_r.mem.write_grant = 1'b1;
			end
			case (r.st)
				mmx_pkg::ST_IDLE: begin
					if (mode == mmx_pkg::MODE_MINMAX && even_phase_clock && store_period_clock) begin
						next_r.st = mmx_pkg::ST_INIT;
					end
				end
				mmx_pkg::ST_INIT: next_r.st = mmx_pkg::ST_TRACK;
				mmx_pkg::ST_TRACK: begin
					if (mode != mmx_pkg::MODE_MINMAX) begin
						next_r.st = mmx_pkg::ST_IDLE;
					end else if (period_end) begin
						next_r.st = mmx_pkg::ST_INIT;
					end
				end
				default: next_r.st = mmx_pkg::ST_IDLE;
			endcase
		end
		if (low_register_clock) begin
			next_r.low_reg = gbus;
		end
		if (high_register_clock) begin
			next_r.high_reg = gbus;
		end
		// latch remembers which extreme moved last; init leaves it alone
		if (r.st == mmx_pkg::ST_TRACK && low_register_clock && !high_register_clock) begin
			next_r.last_max = 1'b0;
		end else if (r.st == mmx_pkg::ST_TRACK && high_register_clock && !low_register_clock) begin
			next_r.last_max = 1'b1;
		end
		if (pre_end) begin
			next_r.mem.output_stage_clock = 1'b1;
			next_r.swap_ff = r.ctrl[mmx_pkg::CTRL_EXCH] ? r.last_max : 1'b1;
			next_r.mem.straight_sel = r.ctrl[mmx_pkg::CTRL_EXCH] ? r.last_max : 1'b1;
			next_r.mem.exchanged_sel = r.ctrl[mmx_pkg::CTRL_EXCH] && !r.last_max;
			// exchanged lanes put the later value in the upper byte
			if (r.ctrl[mmx_pkg::CTRL_EXCH] && !r.last_max) begin
				next_r.mem.word = {r.low_reg, r.high_reg};
			end else begin
				next_r.mem.word = {r.high_reg, r.low_reg};
			end
		end
		// axi4-lite write: address and data taken in either order
		if (s_awvalid && !r.awok && !r.bvalid) begin
			next_r.awok = 1'b1;
			next_r.awaddr = s_awaddr;
		end
		if (s_wvalid && !r.wok && !r.bvalid) begin
			next_r.wok = 1'b1;
			next_r.wdata = s_wdata;
		end
		if (r.awok && r.wok) begin
			next_r.awok = 1'b0;
			next_r.wok = 1'b0;
			next_r.bvalid = 1'b1;
			next_r.bresp = known(r.awaddr) ? mmx_pkg::RESP_OKAY : mmx_pkg::RESP_DECERR;
			if (r.awaddr == mmx_pkg::OFS_CTRL) begin
				next_r.ctrl = merge(r.ctrl, r.wdata, 4'hf) & 32'h0000_000f;
			end else if (r.awaddr == mmx_pkg::OFS_PERIOD) begin
				next_r.period = (r.wdata[15:0] < 16'(mmx_pkg::MIN_COMPARE)) ? 16'(mmx_pkg::MIN_COMPARE) : r.wdata[15:0];
			end
		end
		if (r.bvalid && s_bready) begin
			next_r.bvalid = 1'b0;
		end
		if (s_arvalid && !r.rvalid) begin
			next_r.rvalid = 1'b1;
			next_r.rresp = known(s_araddr) ? mmx_pkg::RESP_OKAY : mmx_pkg::RESP_DECERR;
			case (s_araddr)
				mmx_pkg::OFS_CTRL: next_r.rdata = r.ctrl;
				mmx_pkg::OFS_STATUS: next_r.rdata = {11'h000, r.st, r.last_max, r.swap_ff, r.high_reg, r.low_reg};
				mmx_pkg::OFS_PERIOD: next_r.rdata = {16'h0000, r.period};
				mmx_pkg::OFS_WORD: next_r.rdata = {16'h0000, r.mem.word};
				default: next_r.rdata = 32'h0000_0000;
			endcase
		end
		if (r.rvalid && s_rready) begin
			next_r.rvalid = 1'b0;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			r <= '0;
			r.st <= mmx_pkg::ST_IDLE;
			r.ctrl <= mmx_pkg::CTRL_RESET;
			r.period <= mmx_pkg::PERIOD_RESET;
			r.swap_ff <= 1'b1;
			r.last_max <= 1'b1;
		end else begin
			r <= next_r;
		end
	end

	assign sample_strobe = r.sample_strobe;
	assign sample_clock_n = r.sdiv >= 4'(mmx_pkg::SAMPLE_DIV / 2);
	assign mem_word = r.mem.word;
	assign capture_write_grant = r.mem.write_grant;
	assign straight_sel = r.mem.straight_sel;
	assign exchanged_sel = r.mem.exchanged_sel;
	assign output_stage_clock = r.mem.output_stage_clock;
	assign s_awready = !r.awok && !r.bvalid;
	assign s_wready = !r.wok && !r.bvalid;
	assign s_bvalid = r.bvalid;
	assign s_bresp = r.bresp;
	assign s_arready = !r.rvalid;
	assign s_rvalid = r.rvalid;
	assign s_rdata = r.rdata;
	assign s_rresp = r.rresp;

	chk_low_flag_load: assert property (@(posedge aclk) disable iff (!aresetn)
		(fall_ls && mode == mmx_pkg::MODE_MINMAX && r.st == mmx_pkg::ST_TRACK && below_minimum_flag)
		|=> r.low_reg == $past(gbus)) else $error("low register missed new minimum");
	chk_high_flag_load: assert property (@(posedge aclk) disable iff (!aresetn)
		(fall_ls && mode == mmx_pkg::MODE_MINMAX && r.st == mmx_pkg::ST_TRACK && above_maximum_flag)
		|=> r.high_reg == $past(gbus)) else $error("high register missed new maximum");
	chk_init_both_load: assert property (@(posedge aclk) disable iff (!aresetn)
		(fall_ls && mode == mmx_pkg::MODE_MINMAX && r.st == mmx_pkg::ST_INIT)
		|=> r.low_reg == r.high_reg) else $error("init did not load both registers");
	chk_no_load_high: assert property (@(posedge aclk) disable iff (!aresetn)
		(!fall_ls && !low_register_clock) |=> $stable(r.low_reg)) else $error("low register loaded with strobe high");
	chk_stage_pulse: assert property (@(posedge aclk) disable iff (!aresetn)
		output_stage_clock |=> !output_stage_clock) else $error("output stage clock longer than one cycle");
	chk_straight_force: assert property (@(posedge aclk) disable iff (!aresetn)
		(pre_end && !r.ctrl[mmx_pkg::CTRL_EXCH]) |=> straight_sel && !exchanged_sel) else $error("exchange used while disabled");
	chk_sel_exclusive: assert property (@(posedge aclk) disable iff (!aresetn)
		!(straight_sel && exchanged_sel)) else $error("both lane selects active");
	chk_grant_before_end: assert property (@(posedge aclk) disable iff (!aresetn)
		(rise_ls && r.pcnt == r.period - 16'h0002 && r.period >= 16'h0002) |=> capture_write_grant)
		else $error("write grant late");
	chk_strobe_width: assert property (@(posedge aclk) disable iff (!aresetn)
		$rose(sample_strobe) |-> sample_strobe [*1] ##1 !sample_strobe) else $error("strobe width wrong");
endmodule

// File: dv/mmx_latch_strobe_clock_model.sv
// converter model: hands one byte to the pipeline per sample strobe
// assumes the strobe is a one-cycle pulse on aclk
`timescale 1ns/100ps
module mmx_latch_strobe_clock_model (
	// clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// bench control
	input wire logic use_table,
	input wire logic [7:0] level,
	// converter pins
	input wire logic sample_strobe,
	output logic [7:0] latch_strobe_clock_byte
);
	// table repeats every 8 samples so any 8-sample window holds ff and 00 once
	logic [7:0] tbl [8] = '{8'h40, 8'hff, 8'h40, 8'h40, 8'h00, 8'h40, 8'h40, 8'h40};
	logic [2:0] idx;
	// a new conversion per strobe, held until the next one as real outputs are
	always @(posedge aclk) begin
		if (!aresetn) begin
			idx <= 3'h0;
			latch_strobe_clock_byte <= 8'h80;
		end else if (sample_strobe === 1'h1) begin
			idx <= idx + 3'h1;
			latch_strobe_clock_byte <= use_table ? tbl[idx] : level;
		end
	end
endmodule

// File: dv/tb_mmx_pipeline.sv
// testbench for the min-max pipeline: axi4-lite tasks and memory word checks
// assumes the converter model beside it and a 125 MHz aclk
`timescale 1ns/100ps
`define CHK(nm, ex, got) begin checks_done++; if ((got) !== (ex)) begin err_total++; \
	$display("wrong value %s expected %h seen %h", nm, ex, got); end end
module tb_mmx_pipeline;
	logic aclk = 1'h0;
	logic aresetn = 1'h0;
	logic use_table = 1'h0;
	logic [7:0] latch_strobe_clock_byte;
	logic sample_strobe, sample_clock_n, capture_write_grant, straight_sel, exchanged_sel, output_stage_clock;
	logic [15:0] mem_word, w0, w1;
	logic [3:0] s_awaddr = 4'h0, s_araddr = 4'h0, s_wstrb = 4'hf;
	logic s_awvalid = 1'h0, s_wvalid = 1'h0, s_bready = 1'h0, s_arvalid = 1'h0, s_rready = 1'h0;
	logic [31:0] s_wdata = 32'h0, s_rdata, rd;
	logic s_awready, s_wready, s_bvalid, s_arready, s_rvalid, g, ss, xs;
	logic [1:0] s_bresp, s_rresp;
	int err_total = 0, checks_done = 0, gap, k;
	always #4 aclk = ~aclk;
	mmx_pipeline i_mmx_pipeline (.aclk, .aresetn, .latch_strobe_clock_byte, .sample_strobe, .sample_clock_n, .mem_word,
		.capture_write_grant, .straight_sel, .exchanged_sel, .output_stage_clock, .s_awaddr, .s_awvalid,
		.s_awready, .s_wdata, .s_wstrb, .s_wvalid, .s_wready, .s_bresp, .s_bvalid, .s_bready, .s_araddr,
		.s_arvalid, .s_arready, .s_rdata, .s_rresp, .s_rvalid, .s_rready);
	mmx_latch_strobe_clock_model i_mmx_latch_strobe_clock_model (.aclk, .aresetn, .use_table, .level(8'h5a), .sample_strobe, .latch_strobe_clock_byte);
	task automatic axi_wr(input logic [3:0] a, input logic [31:0] d);
		k = 0;
		s_awaddr <= a;
		s_wdata <= d;
		s_awvalid <= 1'h1;
		s_wvalid <= 1'h1;
		s_bready <= 1'h1;
		do begin
			@(posedge aclk);
			if (s_awvalid && s_awready) s_awvalid <= 1'h0;
			if (s_wvalid && s_wready) s_wvalid <= 1'h0;
			k++;
		end while (s_bvalid !== 1'h1);
		`CHK("bvalid", 1'h1, s_bvalid)
		`CHK("bresp", mmx_pkg::RESP_OKAY, s_bresp)
		s_bready <= 1'h0;
		@(posedge aclk);
	endtask
	task automatic axi_rd(input logic [3:0] a, input logic [1:0] er);
		k = 0;
		s_araddr <= a;
		s_arvalid <= 1'h1;
		s_rready <= 1'h1;
		do begin
			@(posedge aclk);
			if (s_arvalid && s_arready) s_arvalid <= 1'h0;
			k++;
		end while (s_rvalid !== 1'h1);
		`CHK("rvalid", 1'h1, s_rvalid)
		`CHK("rresp", er, s_rresp)
		rd = s_rdata;
		s_rready <= 1'h0;
		@(posedge aclk);
	endtask
	// skips one store period first: the word in flight may predate the change
	task automatic wait_word(output logic [15:0] w);
		repeat (2) begin
			gap = 0;
			do begin
				@(posedge aclk);
				gap++;
			end while (output_stage_clock !== 1'h1 && gap < 600);
			g = capture_write_grant;
			ss = straight_sel;
			xs = exchanged_sel;
			@(posedge aclk);
			w = mem_word;
		end
		`CHK("grant at output clock", 1'h1, g)
	endtask
	task automatic complete_run;
		$display("checks %0d mismatches %0d", checks_done, err_total);
		if (err_total == 0 && checks_done > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	initial begin
		repeat (12) @(posedge aclk);
		aresetn <= 1'h1;
		@(posedge aclk);
		axi_rd(mmx_pkg::OFS_CTRL, mmx_pkg::RESP_OKAY);
		`CHK("ctrl reset", mmx_pkg::CTRL_RESET, rd)
		axi_rd(mmx_pkg::OFS_PERIOD, mmx_pkg::RESP_OKAY);
		`CHK("period reset", mmx_pkg::PERIOD_RESET, rd[15:0])
		axi_rd(4'h2, mmx_pkg::RESP_DECERR);
		$display("test registers done");
		k = 0;
		do begin
			@(posedge aclk);
			k++;
		end while (sample_strobe !== 1'h1 && k < 50);
		@(posedge aclk);
		`CHK("strobe width", 1'h0, sample_strobe)
		k = 1;
		do begin
			@(posedge aclk);
			k++;
		end while (sample_strobe !== 1'h1 && k < 50);
		`CHK("strobe spacing", mmx_pkg::SAMPLE_DIV, k)
		$display("test strobe done");
		// two table rounds per period, so an extreme on the last slot is still seen
		axi_wr(mmx_pkg::OFS_PERIOD, 32'h10);
		wait_word(w0);
		`CHK("sampling word", 16'h5a5a, w0)
		`CHK("sampling lanes", 2'h2, {ss, xs})
		axi_wr(mmx_pkg::OFS_CTRL, 32'h9);
		wait_word(w0);
		`CHK("xy word", 16'h5a5a, w0)
		`CHK("xy lanes", 2'h2, {ss, xs})
		$display("test sampling and xy done");
		use_table <= 1'h1;
		axi_wr(mmx_pkg::OFS_CTRL, 32'ha);
		wait_word(w0);
		wait_word(w1);
		`CHK("store period", mmx_pkg::SAMPLE_DIV * 16 - 1, gap)
		`CHK("minmax word", 1'h1, w0 == 16'hff00 || w0 == 16'h00ff)
		`CHK("fixed lanes", w0, w1)
		axi_wr(mmx_pkg::OFS_CTRL, 32'he);
		wait_word(w0);
		`CHK("exchange word", 1'h1, w0 == 16'hff00 || w0 == 16'h00ff)
		`CHK("one lane select", 1'h1, ss ^ xs)
		$display("test minmax done");
		use_table <= 1'h0;
		axi_wr(mmx_pkg::OFS_CTRL, 32'h2);
		wait_word(w0);
		`CHK("pattern spread", 1'h0, w0[15:8] == w0[7:0])
		axi_wr(mmx_pkg::OFS_CTRL, 32'ha);
		wait_word(w0);
		`CHK("latch back", 16'h5a5a, w0)
		$display("test diagnostic done");
		complete_run();
	end
	// all tests take under two thousand cycles
	initial begin
		repeat (20000) @(posedge aclk);
		err_total++;
		complete_run();
	end
endmodule
